// ==== hw/emt_pkg.sv ====
// Package: constants, carriers and state types of the EEPROM ECC and margin block
package emt_pkg;
	localparam int ROW_W  = 6;
	localparam int DATA_W = 26;
	localparam int ECC_W  = 6;
	localparam int CODE_W = 5;
	localparam int NUM_ROWS = 64;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_ERR_REPORT = 8'h82;
	localparam logic [7:0] ADDR_FAIL_DATA  = 8'h83;
	localparam logic [7:0] ADDR_TEST_CTRL  = 8'h84;
	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int CTL_LOOP_BIT = 13;
	localparam int CTL_ROW_LSB  = 7;
	localparam int CTL_USE_BIT  = 6;
	localparam int CTL_NOMIN_BIT = 2;
	localparam int CTL_NOMAX_BIT = 1;
	localparam int CTL_START_BIT = 0;
	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [1:0] MST_NONE = 2'h0;
	localparam logic [1:0] MST_PASS = 2'h1;
	localparam logic [1:0] MST_FAIL = 2'h2;
	localparam logic [1:0] MST_RUN  = 2'h3;
	localparam logic [1:0] REF_NORMAL = 2'h0;
	localparam logic [1:0] REF_MIN    = 2'h1;
	localparam logic [1:0] REF_MAX    = 2'h2;
	localparam logic [CODE_W-1:0] PUMP_FAULT_CODE = 5'h01;
	localparam logic [ROW_W-1:0]  FIRST_ROW = 6'h00;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic             rdEn;
		logic [ROW_W-1:0] row;
		logic [1:0]       refSel;
	} emt_arr_req_t;
	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
		logic [ECC_W-1:0]  ecc;
		logic              sbe;
		logic              dbe;
		logic [DATA_W-1:0] corr;
		logic              fail;
	} emt_arr_rsp_t;
	typedef struct packed {
		logic              en;
		logic [ROW_W-1:0]  row;
		logic [DATA_W-1:0] data;
	} emt_shadow_wr_t;
	// ----------------------------------------
	// States
	// ----------------------------------------
	typedef enum logic [2:0] {SC_IDLE = 3'b001, SC_ISSUE = 3'b010, SC_WAIT = 3'b100} emt_scan_st_t;
	typedef enum logic [2:0] {MG_IDLE = 3'b001, MG_ISSUE = 3'b010, MG_WAIT = 3'b100} emt_mrg_st_t;
	typedef struct packed {
		emt_scan_st_t     st;
		logic [ROW_W-1:0] row;
		logic             again;
		emt_arr_req_t     req;
		emt_shadow_wr_t   shw;
		logic             sbe;
		logic             dbe;
	} emt_scan_s_t;
	typedef struct packed {
		emt_mrg_st_t       st;
		logic [ROW_W-1:0]  row;
		logic [ROW_W-1:0]  first;
		logic              atMax;
		emt_arr_req_t      req;
		logic              done;
		logic              failed;
		logic [ROW_W-1:0]  failRow;
		logic [ECC_W-1:0]  failEcc;
		logic [DATA_W-1:0] failData;
		logic              failAtMax;
	} emt_mrg_s_t;
	typedef struct packed {
		logic [31:0]       rdData;
		emt_arr_req_t      req;
		logic              loopEn;
		logic [ROW_W-1:0]  startRow;
		logic              useStart;
		logic              skipMin;
		logic              skipMax;
		logic              start;
		logic              failAtMax;
		logic [1:0]        mstat;
		logic [ECC_W-1:0]  failEcc;
		logic [ROW_W-1:0]  failRow;
		logic [DATA_W-1:0] failData;
		logic [CODE_W-1:0] wrCode;
		logic              pump;
		logic              wrFault;
	} emt_ctrl_s_t;
endpackage : emt_pkg

// ==== hw/emt_ecc_scan.sv ====
// ECC scan of all rows after reset and load, with shadow correction
`timescale 1ns/100ps
`default_nettype none
module emt_ecc_scan #(
	parameter int NUM_ROWS = emt_pkg::NUM_ROWS
) (
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	input  wire logic                    loadReq,
	input  wire logic                    grant,
	input  wire emt_pkg::emt_arr_rsp_t   arrRsp,
	output emt_pkg::emt_arr_req_t        req,
	output emt_pkg::emt_shadow_wr_t      shadowWr,
	output logic                         sbeFlag,
	output logic                         dbeFlag,
	output logic                         busy,
	output logic                         pending
);
	localparam logic [emt_pkg::ROW_W-1:0] LAST = emt_pkg::ROW_W'(NUM_ROWS - 1);
	localparam emt_pkg::emt_scan_s_t RST_S = '{st: emt_pkg::SC_ISSUE, default: '0};
	emt_pkg::emt_scan_s_t s_r;
	emt_pkg::emt_scan_s_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.req.rdEn = 1'b0;
		s_nxt.shw.en = 1'b0;
		unique case (s_r.st)
			emt_pkg::SC_IDLE: begin
			end
			emt_pkg::SC_ISSUE: if (grant) begin
				s_nxt.req = '{1'b1, s_r.row, emt_pkg::REF_NORMAL};
				s_nxt.st = emt_pkg::SC_WAIT;
			end
			emt_pkg::SC_WAIT: if (arrRsp.valid) begin
				if (arrRsp.sbe) begin
					s_nxt.sbe = 1'b1; // RULE2
					s_nxt.shw = '{1'b1, s_r.row, arrRsp.corr}; // RULE2
				end
				if (arrRsp.dbe) s_nxt.dbe = 1'b1; // RULE1
				s_nxt.row = s_r.row + 1'b1;
				s_nxt.st = (s_r.row == LAST) ? emt_pkg::SC_IDLE : emt_pkg::SC_ISSUE;
			end
		endcase
		// Restart waits for any read still in flight
		if ((loadReq || s_r.again) && s_nxt.st != emt_pkg::SC_WAIT) begin
			s_nxt.st = emt_pkg::SC_ISSUE; // RULE3
			s_nxt.row = emt_pkg::FIRST_ROW;
			s_nxt.sbe = 1'b0;
			s_nxt.dbe = 1'b0;
			s_nxt.again = 1'b0;
		end else if (loadReq) begin
			s_nxt.again = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) s_r <= RST_S; // RULE3
		else s_r <= s_nxt;
	end

	assign req = s_r.req;
	assign shadowWr = s_r.shw;
	assign sbeFlag = s_r.sbe;
	assign dbeFlag = s_r.dbe;
	assign busy = s_r.st != emt_pkg::SC_IDLE;
	assign pending = s_r.st == emt_pkg::SC_WAIT;
endmodule : emt_ecc_scan
`default_nettype wire

// ==== hw/emt_margin_test.sv ====
// Margin test engine: walks rows against the low and high reference levels
`timescale 1ns/100ps
`default_nettype none
module emt_margin_test #(
	parameter int NUM_ROWS = emt_pkg::NUM_ROWS
) (
	input  wire logic                         clk_sys,
	input  wire logic                         sys_rst,
	input  wire logic                         go,
	input  wire logic                         keepOn,
	input  wire logic                         loopEn,
	input  wire logic                         useStartRow,
	input  wire logic [emt_pkg::ROW_W-1:0]    startRow,
	input  wire logic                         skipMin,
	input  wire logic                         skipMax,
	input  wire logic                         grant,
	input  wire emt_pkg::emt_arr_rsp_t        arrRsp,
	output emt_pkg::emt_arr_req_t             req,
	output logic                              pending,
	output logic                              busy,
	output logic                              done,
	output logic                              failed,
	output logic [emt_pkg::ROW_W-1:0]         failRow,
	output logic [emt_pkg::ECC_W-1:0]         failEcc,
	output logic [emt_pkg::DATA_W-1:0]        failData,
	output logic                              failAtMax
);
	localparam logic [emt_pkg::ROW_W-1:0] LAST = emt_pkg::ROW_W'(NUM_ROWS - 1);
	localparam emt_pkg::emt_mrg_s_t RST_S = '{st: emt_pkg::MG_IDLE, default: '0};
	emt_pkg::emt_mrg_s_t s_r;
	emt_pkg::emt_mrg_s_t s_nxt;

	always_comb begin
		logic adv;
		adv = 1'b0;
		s_nxt = s_r;
		s_nxt.req.rdEn = 1'b0;
		s_nxt.done = 1'b0;
		unique case (s_r.st)
			emt_pkg::MG_IDLE: if (go) begin
				s_nxt.first = useStartRow ? startRow : emt_pkg::FIRST_ROW; // RULE11
				s_nxt.row = s_nxt.first;
				s_nxt.atMax = skipMin; // RULE16
				s_nxt.failed = 1'b0;
				s_nxt.st = emt_pkg::MG_ISSUE;
			end
			emt_pkg::MG_ISSUE: begin
				if (!keepOn) begin
					s_nxt.st = emt_pkg::MG_IDLE; // RULE10
					s_nxt.done = 1'b1;
				end else if (s_r.atMax && skipMax) begin
					adv = 1'b1; // RULE17
				end else if (grant) begin
					s_nxt.req = '{1'b1, s_r.row, s_r.atMax ? emt_pkg::REF_MAX : emt_pkg::REF_MIN}; // RULE21
					s_nxt.st = emt_pkg::MG_WAIT;
				end
			end
			emt_pkg::MG_WAIT: if (arrRsp.valid) begin
				if (arrRsp.fail) begin
					s_nxt.failed = 1'b1; // RULE20
					s_nxt.done = 1'b1;
					s_nxt.st = emt_pkg::MG_IDLE;
					s_nxt.failRow = s_r.row;
					s_nxt.failEcc = arrRsp.ecc;
					s_nxt.failData = arrRsp.data;
					s_nxt.failAtMax = s_r.atMax;
				end else if (!s_r.atMax && !skipMax) begin
					s_nxt.atMax = 1'b1; // RULE17
					s_nxt.st = emt_pkg::MG_ISSUE;
				end else begin
					adv = 1'b1;
				end
			end
		endcase
		// Ascending walk; loop mode restarts at the first row
		if (adv) begin
			s_nxt.atMax = skipMin; // RULE16
			if (s_r.row != LAST) begin
				s_nxt.row = s_r.row + 1'b1; // RULE21
				s_nxt.st = emt_pkg::MG_ISSUE;
			end else if (loopEn && keepOn) begin
				s_nxt.row = s_r.first; // RULE10
				s_nxt.st = emt_pkg::MG_ISSUE;
			end else begin
				s_nxt.st = emt_pkg::MG_IDLE;
				s_nxt.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) s_r <= RST_S;
		else s_r <= s_nxt;
	end

	assign req = s_r.req;
	assign pending = s_r.st == emt_pkg::MG_WAIT;
	assign busy = s_r.st != emt_pkg::MG_IDLE;
	assign done = s_r.done;
	assign failed = s_r.failed;
	assign failRow = s_r.failRow;
	assign failEcc = s_r.failEcc;
	assign failData = s_r.failData;
	assign failAtMax = s_r.failAtMax;
endmodule : emt_margin_test
`default_nettype wire

// ==== hw/emt_ecc_margin_top.sv ====
// Top: ECC status, write result and margin test registers with array arbitration
//
// Behaviour
// RULE1: Double-bit flag bit 20 is set when the scan meets an uncorrectable row.
// RULE2: Single-bit error sets bit 19 and writes the corrected word to shadow.
// RULE3: The ECC scan runs after every reset and every load request.
// RULE4: A margin failure captures the failing row's check bits in bits 18:13.
// RULE5: A margin failure captures the failing row address in bits 12:7.
// RULE6: A margin failure captures the failing row's 26 data bits.
// RULE7: Bits 6:2 hold the last write's result code; nonzero means error.
// RULE8: A pump fault sets bit 1 and forces a nonzero result code.
// RULE9: Bit 0 sets on any write error and clears when its register is read.
// RULE10: Loop bit repeats the test until failure or start bit cleared.
// RULE11: Test starts at row zero, or at the start row field when selected.
// RULE12: A failure overwrites the start row field with the failing row.
// RULE13: Bit 5 tells whether the low or high reference failed.
// RULE14: Status bits 4:3 read none, pass, fail or running.
// RULE15: Status returns to zero when read and on reset.
// RULE16: Skip-minimum bit leaves out the low reference check.
// RULE17: Skip-maximum bit leaves out the high reference check.
// RULE18: Host writes start bit one; the device then begins the test.
// RULE19: Without loop the start bit self-clears at completion; with loop it stays.
// RULE20: Any failure stops the test and clears the start bit.
// RULE21: Rows are visited upward from the start row to the last row.
`timescale 1ns/100ps
`default_nettype none
module emt_ecc_margin_top #(
	parameter int NUM_ROWS = emt_pkg::NUM_ROWS
) (
	input  wire logic                              clk_sys,
	input  wire logic                              sys_rst,
	input  wire logic [7:0]                        regAddr,
	input  wire logic [31:0]                       regWrData,
	input  wire logic                              regWr,
	input  wire logic                              regRd,
	output logic [31:0]                            regRdData,
	input  wire logic                              loadReq,
	input  wire logic                              wrDone,
	input  wire logic [emt_pkg::CODE_W-1:0]        wrResult,
	input  wire logic                              wrPumpFault,
	output emt_pkg::emt_arr_req_t                  arrReq,
	input  wire emt_pkg::emt_arr_rsp_t             arrRsp,
	output emt_pkg::emt_shadow_wr_t                shadowWr
);
	// ----------------------------------------
	// Engines
	// ----------------------------------------
	emt_pkg::emt_ctrl_s_t              s_r;
	emt_pkg::emt_ctrl_s_t              s_nxt;
	emt_pkg::emt_arr_req_t             scanReq;
	emt_pkg::emt_arr_req_t             mrgReq;
	logic                              sbeFlag;
	logic                              dbeFlag;
	logic                              scanBusy;
	logic                              scanPending;
	logic                              mrgPending;
	logic                              mrgBusy;
	logic                              mrgDone;
	logic                              mrgFailed;
	logic [emt_pkg::ROW_W-1:0]         mrgFailRow;
	logic [emt_pkg::ECC_W-1:0]         mrgFailEcc;
	logic [emt_pkg::DATA_W-1:0]        mrgFailData;
	logic                              mrgFailAtMax;
	logic                              wrCtl;
	logic                              rdErr;
	logic                              rdCtl;
	logic [1:0]                        mstatView;

	emt_ecc_scan #(.NUM_ROWS(NUM_ROWS)) uScan (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.loadReq  (loadReq),
		.grant    (!mrgPending),
		.arrRsp   (arrRsp),
		.req      (scanReq),
		.shadowWr (shadowWr),
		.sbeFlag  (sbeFlag),
		.dbeFlag  (dbeFlag),
		.busy     (scanBusy),
		.pending  (scanPending)
	);

	emt_margin_test #(.NUM_ROWS(NUM_ROWS)) uMargin (
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.go          (s_r.start && !mrgDone),
		.keepOn      (s_r.start),
		.loopEn      (s_r.loopEn),
		.useStartRow (s_r.useStart),
		.startRow    (s_r.startRow),
		.skipMin     (s_r.skipMin),
		.skipMax     (s_r.skipMax),
		.grant       (!scanBusy),
		.arrRsp      (arrRsp),
		.req         (mrgReq),
		.pending     (mrgPending),
		.busy        (mrgBusy),
		.done        (mrgDone),
		.failed      (mrgFailed),
		.failRow     (mrgFailRow),
		.failEcc     (mrgFailEcc),
		.failData    (mrgFailData),
		.failAtMax   (mrgFailAtMax)
	);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	assign wrCtl = regWr && regAddr == emt_pkg::ADDR_TEST_CTRL;
	assign rdErr = regRd && regAddr == emt_pkg::ADDR_ERR_REPORT;
	assign rdCtl = regRd && regAddr == emt_pkg::ADDR_TEST_CTRL;
	// Running from the start write until the completion is recorded
	assign mstatView = (mrgBusy || mrgDone || s_r.start) ? emt_pkg::MST_RUN : s_r.mstat; // RULE14

	always_comb begin
		s_nxt = s_r;
		s_nxt.req = scanReq.rdEn ? scanReq : mrgReq;
		// Read data, one cycle after the strobe
		if (regRd) begin
			unique case (regAddr)
				emt_pkg::ADDR_ERR_REPORT: s_nxt.rdData = {11'h0, dbeFlag, sbeFlag, // RULE1
					s_r.failEcc, s_r.failRow, s_r.wrCode, s_r.pump, s_r.wrFault}; // RULE4
				emt_pkg::ADDR_FAIL_DATA: s_nxt.rdData = {6'h00, s_r.failData}; // RULE6
				emt_pkg::ADDR_TEST_CTRL: s_nxt.rdData = {18'h0, s_r.loopEn, s_r.startRow,
					s_r.useStart, s_r.failAtMax, mstatView, s_r.skipMin, s_r.skipMax, s_r.start};
				default: s_nxt.rdData = 32'h00000000;
			endcase
		end
		// Host control write
		if (wrCtl) begin
			s_nxt.loopEn = regWrData[emt_pkg::CTL_LOOP_BIT];
			s_nxt.startRow = regWrData[emt_pkg::CTL_ROW_LSB +: emt_pkg::ROW_W];
			s_nxt.useStart = regWrData[emt_pkg::CTL_USE_BIT];
			s_nxt.skipMin = regWrData[emt_pkg::CTL_NOMIN_BIT];
			s_nxt.skipMax = regWrData[emt_pkg::CTL_NOMAX_BIT];
			s_nxt.start = regWrData[emt_pkg::CTL_START_BIT]; // RULE18
		end
		// Clear on read; a same-cycle event below wins
		if (rdErr) s_nxt.wrFault = 1'b0; // RULE9
		if (rdCtl) s_nxt.mstat = emt_pkg::MST_NONE; // RULE15
		// Result of the last EEPROM write
		if (wrDone) begin
			s_nxt.wrCode = (wrPumpFault && wrResult == '0) ? emt_pkg::PUMP_FAULT_CODE : wrResult; // RULE7 RULE8
			s_nxt.pump = wrPumpFault; // RULE8
			if (wrPumpFault || wrResult != '0) s_nxt.wrFault = 1'b1; // RULE9
		end
		// Margin completion
		if (mrgDone) begin
			if (mrgFailed) begin
				s_nxt.mstat = emt_pkg::MST_FAIL; // RULE14
				s_nxt.failRow = mrgFailRow; // RULE5
				s_nxt.failEcc = mrgFailEcc; // RULE4
				s_nxt.failData = mrgFailData; // RULE6
				s_nxt.failAtMax = mrgFailAtMax; // RULE13
				s_nxt.startRow = mrgFailRow; // RULE12
				s_nxt.start = 1'b0; // RULE20
			end else begin
				s_nxt.mstat = emt_pkg::MST_PASS; // RULE14
				if (!s_r.loopEn && !wrCtl) s_nxt.start = 1'b0; // RULE19
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) s_r <= '0; // RULE15
		else s_r <= s_nxt;
	end

	assign regRdData = s_r.rdData;
	assign arrReq = s_r.req;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_dbe_cause;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(dbeFlag) |-> $past(scanPending && arrRsp.valid && arrRsp.dbe);
	endproperty
	a_dbe_cause: assert property (p_dbe_cause) else $error("double-bit flag without cause"); // RULE1

	property p_sbe_shadow;
		@(posedge clk_sys) disable iff (sys_rst)
		scanPending && arrRsp.valid && arrRsp.sbe |=> shadowWr.en
			&& (sbeFlag || $past(loadReq || uScan.s_r.again))
			&& shadowWr.data == $past(arrRsp.corr);
	endproperty
	a_sbe_shadow: assert property (p_sbe_shadow) else $error("corrected word not written"); // RULE2

	property p_load_scan;
		@(posedge clk_sys) disable iff (sys_rst)
		loadReq && !scanPending |=> scanBusy && (scanPending || !sbeFlag && !dbeFlag);
	endproperty
	a_load_scan: assert property (p_load_scan) else $error("load did not restart scan"); // RULE3

	property p_fail_capture;
		@(posedge clk_sys) disable iff (sys_rst)
		mrgDone && mrgFailed |=> s_r.failRow == $past(mrgFailRow)
			&& s_r.failEcc == $past(mrgFailEcc) && s_r.failData == $past(mrgFailData);
	endproperty
	a_fail_capture: assert property (p_fail_capture) else $error("failing row not captured"); // RULE5

	property p_fail_stop;
		@(posedge clk_sys) disable iff (sys_rst)
		mrgDone && mrgFailed |=> !s_r.start && s_r.mstat == emt_pkg::MST_FAIL
			&& s_r.startRow == s_r.failRow ##1 !mrgBusy;
	endproperty
	a_fail_stop: assert property (p_fail_stop) else $error("failure did not stop test"); // RULE20

	property p_pump;
		@(posedge clk_sys) disable iff (sys_rst)
		wrDone && wrPumpFault |=> s_r.pump && s_r.wrCode != '0 && s_r.wrFault;
	endproperty
	a_pump: assert property (p_pump) else $error("pump fault not reported"); // RULE8

	property p_fault_rdclr;
		@(posedge clk_sys) disable iff (sys_rst)
		rdErr && !wrDone |=> !s_r.wrFault;
	endproperty
	a_fault_rdclr: assert property (p_fault_rdclr) else $error("write fault not cleared"); // RULE9

	property p_stat_rdclr;
		@(posedge clk_sys) disable iff (sys_rst)
		rdCtl && !mrgDone |=> s_r.mstat == emt_pkg::MST_NONE;
	endproperty
	a_stat_rdclr: assert property (p_stat_rdclr) else $error("status not cleared on read"); // RULE15

	property p_once_clear;
		@(posedge clk_sys) disable iff (sys_rst)
		mrgDone && !mrgFailed && !s_r.loopEn && !wrCtl |=> !s_r.start;
	endproperty
	a_once_clear: assert property (p_once_clear) else $error("start bit not self-cleared"); // RULE19

	property p_run_read;
		@(posedge clk_sys) disable iff (sys_rst)
		rdCtl && mrgBusy |=> regRdData[4:3] == emt_pkg::MST_RUN;
	endproperty
	a_run_read: assert property (p_run_read) else $error("running status not shown"); // RULE14

	property p_start_go;
		@(posedge clk_sys) disable iff (sys_rst)
		s_r.start && !mrgBusy && !mrgDone |=> mrgBusy;
	endproperty
	a_start_go: assert property (p_start_go) else $error("test did not begin"); // RULE18

	property p_cov_fail;
		@(posedge clk_sys) disable iff (sys_rst)
		mrgDone && mrgFailed;
	endproperty
	c_cov_fail: cover property (p_cov_fail);

	property p_cov_pass;
		@(posedge clk_sys) disable iff (sys_rst)
		mrgDone && !mrgFailed;
	endproperty
	c_cov_pass: cover property (p_cov_pass);

	property p_cov_sbe;
		@(posedge clk_sys) disable iff (sys_rst)
		shadowWr.en;
	endproperty
	c_cov_sbe: cover property (p_cov_sbe);
endmodule : emt_ecc_margin_top
`default_nettype wire

// ==== tb/emt_array_model.sv ====
// Array model: answers row reads with fixed data, planted ECC and margin faults
`timescale 1ns/100ps
`default_nettype none
module emt_array_model (
	input  wire logic                  clk_sys,
	input  wire logic                  sys_rst,
	input  wire logic                  slow,
	input  wire logic [7:0]            sbeRow,
	input  wire logic [7:0]            dbeRow,
	input  wire logic [7:0]            failRow,
	input  wire logic [1:0]            failRef,
	input  wire emt_pkg::emt_arr_req_t req,
	output emt_pkg::emt_arr_rsp_t      rsp,
	output logic [7:0]                 lowCnt,
	output logic [7:0]                 highCnt
);
	logic [5:0] rowQ;
	logic [1:0] refQ;
	logic [1:0] cnt;
	// ----------------------------------------
	// Answer after one or three cycles; lines toggle when idle
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rsp <= '0;
			cnt <= 2'h0;
			lowCnt <= 8'h00;
			highCnt <= 8'h00;
		end else begin
			rsp <= ~rsp;
			rsp.valid <= 1'b0;
			if (req.rdEn) begin
				rowQ <= req.row;
				refQ <= req.refSel;
				cnt <= slow ? 2'h3 : 2'h1;
				lowCnt <= lowCnt + 8'(req.refSel == emt_pkg::REF_MIN);
				highCnt <= highCnt + 8'(req.refSel == emt_pkg::REF_MAX);
			end else if (cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
				if (cnt == 2'h1) begin
					rsp.valid <= 1'b1;
					rsp.data <= 26'h2a5a5a0 ^ 26'(rowQ);
					rsp.ecc <= 6'h15 ^ rowQ;
					rsp.sbe <= refQ == 2'h0 && 8'(rowQ) == sbeRow;
					rsp.dbe <= refQ == 2'h0 && 8'(rowQ) == dbeRow;
					rsp.corr <= ~(26'h2a5a5a0 ^ 26'(rowQ));
					rsp.fail <= refQ == failRef && 8'(rowQ) == failRow;
				end
			end
		end
	end
endmodule : emt_array_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Testbench of the EEPROM ECC and margin block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic        regWr = 0, regRd = 0, loadReq = 0, wrDone = 0, wrPumpFault = 0, slow = 0;
	logic [4:0]  wrResult = 5'h00;
	logic [7:0]  sbeRow = 8'h01, dbeRow = 8'h02, failRow = 8'hff, lowCnt, highCnt, lo0, hi0;
	logic [1:0]  failRef = 2'h1;
	logic [31:0] rd;
	logic [29:0] mTab [4] = '{{14'h1, 8'h4, 8'h4}, {14'h5, 8'h0, 8'h4}, {14'h3, 8'h4, 8'h0},
		{14'h141, 8'h2, 8'h2}};
	logic [12:0] wTab [4] = '{{5'h00, 1'b0, 7'h00}, {5'h0a, 1'b0, 7'h29},
		{5'h00, 1'b1, 7'h07}, {5'h03, 1'b1, 7'h0f}};
	logic [5:0]  shwRow;
	logic [25:0] shwData;
	int          comparisons = 0, mismatches = 0;
	emt_pkg::emt_arr_req_t   arrReq;
	emt_pkg::emt_arr_rsp_t   arrRsp;
	emt_pkg::emt_shadow_wr_t shadowWr;
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (shadowWr.en === 1'b1) begin
		shwRow <= shadowWr.row;
		shwData <= shadowWr.data;
	end
	emt_ecc_margin_top #(.NUM_ROWS(4)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(rd), .loadReq(loadReq), .wrDone(wrDone), .wrResult(wrResult),
		.wrPumpFault(wrPumpFault), .arrReq(arrReq), .arrRsp(arrRsp), .shadowWr(shadowWr));
	emt_array_model u_arr (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
		.sbeRow(sbeRow), .dbeRow(dbeRow), .failRow(failRow), .failRef(failRef),
		.req(arrReq), .rsp(arrRsp), .lowCnt(lowCnt), .highCnt(highCnt));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [25:0] dat(input logic [5:0] r);
		return 26'h2a5a5a0 ^ 26'(r);
	endfunction : dat
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_sys) {regAddr, regWrData, regWr} = {a, d, 1'b1};
		@(negedge clk_sys) regWr = 1'b0;
	endtask : wrReg
	task automatic rdReg(input logic [7:0] a);
		@(negedge clk_sys) {regAddr, regRd} = {a, 1'b1};
		@(negedge clk_sys) regRd = 1'b0;
		@(negedge clk_sys);
	endtask : rdReg
	task automatic pollReg(input logic [7:0] a, input logic [31:0] m, v, input logic neq);
		int i;
		for (i = 0; i < 300; i++) begin
			rdReg(a);
			if (((rd & m) === v) != neq) break;
		end
		if (i == 300) begin
			mismatches++;
			tally_and_finish();
		end
	endtask : pollReg
	task automatic margin(input logic [31:0] c);
		lo0 = lowCnt;
		hi0 = highCnt;
		wrReg(emt_pkg::ADDR_TEST_CTRL, c);
		repeat (4) @(negedge clk_sys);
		pollReg(emt_pkg::ADDR_TEST_CTRL, 32'h18, 32'h18, 1'b1);
	endtask : margin
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge clk_sys);
		sys_rst = 1'b0;
		pollReg(emt_pkg::ADDR_ERR_REPORT, 32'h180000, 32'h180000, 1'b0);
		`CHK(shwRow, 6'h01)
		`CHK(shwData, ~dat(6'h01))
		{sbeRow, dbeRow} = {8'hff, 8'h03};
		@(negedge clk_sys) loadReq = 1'b1;
		@(negedge clk_sys) loadReq = 1'b0;
		pollReg(emt_pkg::ADDR_ERR_REPORT, 32'h180000, 32'h100000, 1'b0);
		foreach (wTab[i]) begin
			@(negedge clk_sys) {wrResult, wrPumpFault, wrDone} = {wTab[i][12:7], 1'b1};
			@(negedge clk_sys) wrDone = 1'b0;
			rdReg(emt_pkg::ADDR_ERR_REPORT);
			`CHK(rd[6:0], wTab[i][6:0])
			rdReg(emt_pkg::ADDR_ERR_REPORT);
			`CHK(rd[6:0], wTab[i][6:0] & 7'h7e)
		end
		foreach (mTab[i]) begin
			margin(32'(mTab[i][29:16]));
			`CHK({rd[4:3], rd[0]}, 3'b010)
			`CHK(lowCnt - lo0, mTab[i][15:8])
			`CHK(highCnt - hi0, mTab[i][7:0])
			rdReg(emt_pkg::ADDR_TEST_CTRL);
			`CHK(rd[4:3], emt_pkg::MST_NONE)
		end
		{failRow, failRef} = {8'h02, 2'h2};
		margin(32'h20c1);
		`CHK(rd[13:0], {1'b1, 6'h02, 1'b1, 1'b1, 2'h2, 3'h0})
		rdReg(emt_pkg::ADDR_ERR_REPORT);
		`CHK(rd[18:7], {6'h17, 6'h02})
		rdReg(emt_pkg::ADDR_FAIL_DATA);
		`CHK(rd[25:0], dat(6'h02))
		{failRow, failRef} = {8'h03, 2'h1};
		margin(32'h3);
		`CHK(rd[12:0], {6'h03, 1'b0, 1'b0, 2'h2, 3'h2})
		{failRow, slow, hi0} = {8'hff, 1'b1, highCnt};
		wrReg(emt_pkg::ADDR_TEST_CTRL, 32'h2001);
		for (int i = 0; i < 500 && highCnt - hi0 < 8'd9; i++) @(negedge clk_sys);
		`CHK(highCnt - hi0 > 8'd8, 1'b1)
		if (highCnt - hi0 < 8'd9) tally_and_finish();
		rdReg(emt_pkg::ADDR_TEST_CTRL);
		`CHK({rd[4:3], rd[0]}, 3'b111)
		margin(32'h0);
		`CHK({rd[4:3], rd[0]}, 3'b010)
		wrReg(emt_pkg::ADDR_TEST_CTRL, 32'h1);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		sys_rst = 1'b0;
		rdReg(emt_pkg::ADDR_TEST_CTRL);
		`CHK(rd, 32'h0)
		rdReg(8'h85);
		`CHK(rd, 32'h0)
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
